// File: src/fci_pkg.sv
`default_nettype none
package fci_pkg;
    localparam int BYTE_BITS = 8;
    localparam int MAT_DIM = 4;
    localparam int MAT_BITS = MAT_DIM * MAT_DIM;
    localparam int NSTATE = 8;
    localparam int SURV = 16;
    localparam int PM_W = 6;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_AW = 1;
    localparam int BUF_W = 9;
    // generators 17 and 15 octal, constraint length four
    localparam logic [3:0] GEN_A = 4'hf;
    localparam logic [3:0] GEN_B = 4'hd;
    localparam logic [1:0] LEN_FIXED = 2'h0;
    localparam logic [PM_W-1:0] PM_BAD = 6'h20;
    localparam logic [3:0] ENC_LAST = 4'h7;
    localparam logic [3:0] SEND_FEC = 4'hf;
    localparam logic [3:0] SEND_RAW = 4'h7;
    localparam logic [3:0] FILL_LAST = 4'hf;
    localparam logic [2:0] PAIR_LAST = 3'h7;
    localparam logic [1:0] PAD_ODD = 2'h1;
    localparam logic [1:0] PAD_EVEN = 2'h2;
    localparam logic [11:0] DEC_LAG = 12'h00f;
    typedef enum logic [1:0] {
        T_IDLE = 2'b00,
        T_ENC = 2'b01,
        T_SEND = 2'b10
    } fci_tx_e;
    typedef enum logic [1:0] {
        R_IDLE = 2'b00,
        R_FILL = 2'b01,
        R_DEC = 2'b10,
        R_FLUSH = 2'b11
    } fci_rx_e;
    // row-major index of the k-th bit taken column by column
    function automatic logic [3:0] fci_col_idx(input logic [3:0] k);
        return {k[1:0], k[3:2]};
    endfunction : fci_col_idx
    function automatic logic [1:0] fci_enc(input logic b, input logic [2:0] s);
        return {^({b, s} & GEN_A), ^({b, s} & GEN_B)};
    endfunction : fci_enc
endpackage : fci_pkg
`default_nettype wire

// File: src/fci_codec.sv
`timescale 1ns/1ps
`default_nettype none
module fci_codec
    import fci_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic error_correction_enable,
    input wire logic [1:0] length_format,
    input wire logic tx_in_valid,
    output logic tx_in_ready,
    input wire logic [7:0] tx_in_data,
    input wire logic tx_in_last,
    output logic tx_out_valid,
    input wire logic tx_out_ready,
    output logic tx_out_bit,
    output logic tx_out_last,
    input wire logic rx_start,
    input wire logic [7:0] payload_len,
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    input wire logic rx_in_bit,
    output logic rx_out_valid,
    input wire logic rx_out_ready,
    output logic [7:0] rx_out_data,
    output logic rx_out_last
);
    logic fec_ok;
    logic tx_mode;
    assign fec_ok = error_correction_enable && (length_format == LEN_FIXED);
    fci_tx_e tx_st_q, tx_st_d;
    logic tx_fec_q, tx_fec_d, tx_inpkt_q, tx_inpkt_d, tx_odd_q, tx_odd_d;
    logic end_q, end_d;
    logic [1:0] pad_q, pad_d;
    logic [7:0] byte_q, byte_d;
    logic [2:0] enc_q, enc_d;
    logic [MAT_BITS-1:0] mat_q, mat_d, sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] cw;
    // mode is frozen for the whole packet so a mid-packet change cannot split it
    assign tx_mode = tx_inpkt_q ? tx_fec_q : fec_ok;
    always_comb begin
        tx_st_d = tx_st_q;
        tx_fec_d = tx_fec_q;
        tx_inpkt_d = tx_inpkt_q;
        tx_odd_d = tx_odd_q;
        end_d = end_q;
        pad_d = pad_q;
        byte_d = byte_q;
        enc_d = enc_q;
        mat_d = mat_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        tx_in_ready = 1'b0;
        cw = fci_enc(byte_q[7], enc_q);
        unique case (tx_st_q)
            T_IDLE: begin
                if (pad_q != 2'h0) begin
                    byte_d = 8'h00;
                    pad_d = pad_q - 2'h1;
                    end_d = (pad_q == PAD_ODD);
                    cnt_d = 4'h0;
                    tx_st_d = T_ENC;
                end else begin
                    tx_in_ready = 1'b1;
                    if (tx_in_valid) begin
                        byte_d = tx_in_data;
                        tx_fec_d = tx_mode;
                        if (!tx_inpkt_q) begin
                            enc_d = 3'h0;
                        end
                        tx_odd_d = !(tx_inpkt_q && tx_odd_q);
                        tx_inpkt_d = !tx_in_last;
                        end_d = tx_in_last && !tx_mode;
                        if (tx_in_last && tx_mode) begin
                            pad_d = tx_odd_d ? PAD_ODD : PAD_EVEN;
                        end
                        if (tx_mode) begin
                            cnt_d = 4'h0;
                            tx_st_d = T_ENC;
                        end else begin
                            sh_d = {tx_in_data, 8'h00};
                            cnt_d = SEND_RAW;
                            tx_st_d = T_SEND;
                        end
                    end
                end
            end
            T_ENC: begin
                mat_d[{cnt_q[2:0], 1'b0}] = cw[1];
                mat_d[{cnt_q[2:0], 1'b1}] = cw[0];
                enc_d = {byte_q[7], enc_q[2:1]};
                byte_d = {byte_q[6:0], 1'b0};
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == ENC_LAST) begin
                    for (int k = 0; k < MAT_BITS; k++) begin
                        sh_d[MAT_BITS-1-k] = mat_d[fci_col_idx(4'(k))];
                    end
                    cnt_d = SEND_FEC;
                    tx_st_d = T_SEND;
                end
            end
            T_SEND: begin
                if (tx_out_ready) begin
                    sh_d = {sh_q[MAT_BITS-2:0], 1'b0};
                    cnt_d = cnt_q - 4'h1;
                    if (cnt_q == 4'h0) begin
                        tx_st_d = T_IDLE;
                    end
                end
            end
            default: tx_st_d = T_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_q <= T_IDLE;
            tx_fec_q <= 1'b0;
            tx_inpkt_q <= 1'b0;
            tx_odd_q <= 1'b0;
            end_q <= 1'b0;
            pad_q <= 2'h0;
            byte_q <= 8'h00;
            enc_q <= 3'h0;
            mat_q <= 16'h0000;
            sh_q <= 16'h0000;
            cnt_q <= 4'h0;
        end else begin
            tx_st_q <= tx_st_d;
            tx_fec_q <= tx_fec_d;
            tx_inpkt_q <= tx_inpkt_d;
            tx_odd_q <= tx_odd_d;
            end_q <= end_d;
            pad_q <= pad_d;
            byte_q <= byte_d;
            enc_q <= enc_d;
            mat_q <= mat_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
        end
    end
    assign tx_out_valid = (tx_st_q == T_SEND);
    assign tx_out_bit = sh_q[MAT_BITS-1];
    assign tx_out_last = (tx_st_q == T_SEND) && (cnt_q == 4'h0) && end_q;

    fci_rx_e rx_st_q, rx_st_d;
    logic rx_fec_q, rx_fec_d, ofull_q, ofull_d, olast_q, olast_d;
    logic [10:0] len8_q, len8_d, ocnt_q, ocnt_d;
    logic [11:0] tot_q, tot_d, dec_q, dec_d, pos;
    logic [MAT_BITS-1:0] rmat_q, rmat_d;
    logic [3:0] rcnt_q, rcnt_d;
    logic [2:0] obit_q, obit_d, nsv, best;
    logic [7:0] obyte_q, obyte_d;
    logic [PM_W-1:0] pm_q [NSTATE];
    logic [PM_W-1:0] pm_d [NSTATE];
    logic [PM_W-1:0] acs_pm [NSTATE];
    logic [SURV-1:0] sur_q [NSTATE];
    logic [SURV-1:0] sur_d [NSTATE];
    logic [SURV-1:0] acs_sur [NSTATE];
    logic [PM_W-1:0] mn, ma, mb;
    logic [1:0] sym, xa, xb;
    logic emit, ebit, push;
    logic [1:0] bcnt_q, bcnt_d;
    assign push = ofull_q && (bcnt_q != 2'(BUF_DEPTH));
    always_comb begin
        rx_st_d = rx_st_q;
        rx_fec_d = rx_fec_q;
        len8_d = len8_q;
        tot_d = tot_q;
        dec_d = dec_q;
        ocnt_d = ocnt_q;
        rmat_d = rmat_q;
        rcnt_d = rcnt_q;
        obit_d = obit_q;
        obyte_d = obyte_q;
        ofull_d = ofull_q && !push;
        olast_d = olast_q;
        pm_d = pm_q;
        sur_d = sur_q;
        rx_in_ready = 1'b0;
        emit = 1'b0;
        ebit = 1'b0;
        pos = tot_q - 12'h001 - {1'b0, ocnt_q};
        sym = {rmat_q[{rcnt_q[2:0], 1'b0}], rmat_q[{rcnt_q[2:0], 1'b1}]};
        mn = pm_q[0];
        for (int i = 1; i < NSTATE; i++) begin
            if (pm_q[i] < mn) begin
                mn = pm_q[i];
            end
        end
        // add-compare-select; metrics renormalised by the old minimum every step
        for (int n = 0; n < NSTATE; n++) begin
            nsv = 3'(n);
            xa = fci_enc(nsv[2], {nsv[1:0], 1'b0}) ^ sym;
            xb = fci_enc(nsv[2], {nsv[1:0], 1'b1}) ^ sym;
            ma = pm_q[{nsv[1:0], 1'b0}] - mn + PM_W'(xa[0]) + PM_W'(xa[1]);
            mb = pm_q[{nsv[1:0], 1'b1}] - mn + PM_W'(xb[0]) + PM_W'(xb[1]);
            if (mb < ma) begin
                acs_pm[n] = mb;
                acs_sur[n] = {sur_q[{nsv[1:0], 1'b1}][SURV-2:0], nsv[2]};
            end else begin
                acs_pm[n] = ma;
                acs_sur[n] = {sur_q[{nsv[1:0], 1'b0}][SURV-2:0], nsv[2]};
            end
        end
        best = 3'h0;
        for (int i = 1; i < NSTATE; i++) begin
            if (acs_pm[i] < acs_pm[best]) begin
                best = 3'(i);
            end
        end
        unique case (rx_st_q)
            R_IDLE: begin
                if (rx_start) begin
                    rx_fec_d = fec_ok;
                    len8_d = {payload_len, 3'h0};
                    tot_d = {{1'b0, payload_len} + {7'h00, payload_len[0] ? PAD_ODD : PAD_EVEN}, 3'h0};
                    dec_d = 12'h000;
                    ocnt_d = 11'h000;
                    rcnt_d = 4'h0;
                    obit_d = 3'h0;
                    for (int i = 0; i < NSTATE; i++) begin
                        pm_d[i] = (i == 0) ? '0 : PM_BAD;
                        sur_d[i] = '0;
                    end
                    rx_st_d = R_FILL;
                end
            end
            R_FILL: begin
                if (rx_fec_q) begin
                    rx_in_ready = 1'b1;
                    if (rx_in_valid) begin
                        rmat_d[fci_col_idx(rcnt_q)] = rx_in_bit;
                        rcnt_d = rcnt_q + 4'h1;
                        if (rcnt_q == FILL_LAST) begin
                            rx_st_d = R_DEC;
                        end
                    end
                end else if (ocnt_q == len8_q) begin
                    rx_st_d = R_IDLE;
                end else begin
                    rx_in_ready = !ofull_q;
                    emit = rx_in_valid && !ofull_q;
                    ebit = rx_in_bit;
                end
            end
            R_DEC: begin
                // a full output byte stalls decoding, so the FIFO back-pressure reaches rx_in_ready
                if (!ofull_q) begin
                    pm_d = acs_pm;
                    sur_d = acs_sur;
                    dec_d = dec_q + 12'h001;
                    emit = (dec_q >= DEC_LAG) && (ocnt_q < len8_q);
                    ebit = acs_sur[best][SURV-1];
                    rcnt_d = {1'b0, rcnt_q[2:0] + 3'h1};
                    if (rcnt_q[2:0] == PAIR_LAST) begin
                        rx_st_d = (dec_d == tot_q) ? R_FLUSH : R_FILL;
                    end
                end
            end
            R_FLUSH: begin
                // padding zeros drive the trellis home, so state zero holds the best path
                if (ocnt_q == len8_q) begin
                    rx_st_d = ofull_q ? R_FLUSH : R_IDLE;
                end else begin
                    emit = !ofull_q;
                    ebit = sur_q[0][pos[3:0]];
                end
            end
        endcase
        if (emit) begin
            obyte_d = {obyte_q[6:0], ebit};
            obit_d = obit_q + 3'h1;
            ocnt_d = ocnt_q + 11'h001;
            if (obit_q == PAIR_LAST) begin
                ofull_d = 1'b1;
                olast_d = (ocnt_d == len8_q);
            end
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_q <= R_IDLE;
            rx_fec_q <= 1'b0;
            len8_q <= 11'h000;
            tot_q <= 12'h000;
            dec_q <= 12'h000;
            ocnt_q <= 11'h000;
            rmat_q <= 16'h0000;
            rcnt_q <= 4'h0;
            obit_q <= 3'h0;
            obyte_q <= 8'h00;
            ofull_q <= 1'b0;
            olast_q <= 1'b0;
            pm_q <= '{default: '0};
            sur_q <= '{default: '0};
        end else begin
            rx_st_q <= rx_st_d;
            rx_fec_q <= rx_fec_d;
            len8_q <= len8_d;
            tot_q <= tot_d;
            dec_q <= dec_d;
            ocnt_q <= ocnt_d;
            rmat_q <= rmat_d;
            rcnt_q <= rcnt_d;
            obit_q <= obit_d;
            obyte_q <= obyte_d;
            ofull_q <= ofull_d;
            olast_q <= olast_d;
            pm_q <= pm_d;
            sur_q <= sur_d;
        end
    end

    logic [BUF_W-1:0] buf_q [BUF_DEPTH];
    logic [BUF_W-1:0] buf_d [BUF_DEPTH];
    logic [BUF_AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic pop;
    assign pop = rx_out_valid && rx_out_ready;
    always_comb begin
        buf_d = buf_q;
        wp_d = wp_q;
        rp_d = rp_q;
        bcnt_d = bcnt_q;
        if (push) begin
            buf_d[wp_q] = {olast_q, obyte_q};
            wp_d = wp_q + 1'b1;
        end
        if (pop) begin
            rp_d = rp_q + 1'b1;
        end
        if (push && !pop) begin
            bcnt_d = bcnt_q + 2'h1;
        end else if (pop && !push) begin
            bcnt_d = bcnt_q - 2'h1;
        end
    end
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            buf_q <= '{default: '0};
            wp_q <= '0;
            rp_q <= '0;
            bcnt_q <= 2'h0;
        end else begin
            buf_q <= buf_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            bcnt_q <= bcnt_d;
        end
    end
    assign rx_out_valid = (bcnt_q != 2'h0);
    assign rx_out_data = buf_q[rp_q][7:0];
    assign rx_out_last = buf_q[rp_q][8];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take_fec;
        tx_st_q == T_IDLE && pad_q == 2'h0 && tx_in_valid && tx_mode;
    endsequence
    sequence s_encode;
        (tx_st_q == T_ENC) [*8] ##1 (tx_st_q == T_SEND && cnt_q == SEND_FEC);
    endsequence
    AST_TX_ENC8: assert property (s_take_fec |=> s_encode)
        else $error("coded byte did not take eight coder steps");
    AST_TX_GATE: assert property ((tx_st_q == T_IDLE && pad_q == 2'h0 && !tx_inpkt_q
        && tx_in_valid && !fec_ok) |=> (!tx_fec_q && tx_st_q == T_SEND && cnt_q == SEND_RAW))
        else $error("coding used while not enabled");
    AST_TX_COL: assert property ((tx_st_q == T_SEND && tx_fec_q && cnt_q == SEND_FEC
        && tx_out_bit == mat_q[0] && tx_out_ready) |=> (tx_out_bit == mat_q[4]))
        else $error("interleaver not read by columns");
    AST_TX_FIRST: assert property ($rose(tx_st_q == T_SEND) && tx_fec_q
        |-> tx_out_bit == mat_q[0])
        else $error("first sent bit is not matrix corner");
    AST_TX_PAD: assert property ((s_take_fec and tx_in_last)
        |=> pad_q == (tx_odd_q ? PAD_ODD : PAD_EVEN))
        else $error("wrong pad byte count");
    AST_TX_TERM: assert property ((tx_st_q == T_IDLE && pad_q != 2'h0)
        |=> (tx_st_q == T_ENC && byte_q == 8'h00 && tx_fec_q))
        else $error("termination byte not coded as zero");
    AST_RX_DEINT: assert property ((rx_st_q == R_FILL && rx_fec_q && rx_in_valid)
        |=> rmat_q[fci_col_idx($past(rcnt_q))] == $past(rx_in_bit))
        else $error("symbol not stored column-wise");
    AST_RX_BLOCK: assert property ((rx_st_q == R_FILL && rx_fec_q && rx_in_valid
        && rcnt_q == FILL_LAST) |=> (rx_st_q == R_DEC && rcnt_q == 4'h0))
        else $error("de-interleave block is not sixteen symbols");
    AST_RX_HIDE: assert property ((ofull_q && olast_q) |-> ocnt_q == len8_q)
        else $error("pad data reached the output");
    AST_BUF_BOUND: assert property (bcnt_q <= 2'(BUF_DEPTH))
        else $error("output buffer overrun");
endmodule : fci_codec
`default_nettype wire

// File: dv/fci_modem_model.sv
`timescale 1ns/1ps
`default_nettype none
module fci_modem_model (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic go,
    input wire logic [7:0] flip_at,
    input wire logic tx_out_valid,
    output logic tx_out_ready,
    input wire logic tx_out_bit,
    input wire logic tx_out_last,
    output logic rx_in_valid,
    input wire logic rx_in_ready,
    output logic rx_in_bit,
    output logic done
);
    logic cap_q[$];
    logic tgl_q;
    int w;
    // slow mode takes a bit only every other cycle, so the modem side stalls
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_out_ready <= 1'b0;
            tgl_q <= 1'b0;
            done <= 1'b0;
        end else begin
            tgl_q <= ~tgl_q;
            tx_out_ready <= slow ? tgl_q : 1'b1;
            if (go) begin
                done <= 1'b0;
            end
            if (tx_out_valid && tx_out_ready) begin
                cap_q.push_back(tx_out_bit);
                if (tx_out_last) begin
                    done <= 1'b1;
                end
            end
        end
    end
    // replays the captured air stream; one symbol may be inverted on purpose
    initial begin
        rx_in_valid = 1'b0;
        rx_in_bit = 1'b0;
        forever begin
            @(posedge sys_clk);
            if (go) begin
                for (int i = 0; i < cap_q.size(); i++) begin
                    #1;
                    rx_in_valid = 1'b1;
                    rx_in_bit = cap_q[i] ^ (i == int'(flip_at));
                    // ready comes from registers, so it is judged where it has settled
                    for (w = 0; !rx_in_ready && w < 5000; w++) begin
                        @(posedge sys_clk);
                        #1;
                    end
                    @(posedge sys_clk);
                    if (slow) begin
                        #1;
                        rx_in_valid = 1'b0;
                        rx_in_bit = ~rx_in_bit;
                        @(posedge sys_clk);
                    end
                end
                #1;
                rx_in_valid = 1'b0;
                rx_in_bit = ~rx_in_bit;
                cap_q.delete();
            end
        end
    end
endmodule : fci_modem_model
`default_nettype wire

// File: dv/tb_fci_codec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fci_codec;
    import fci_pkg::*;
    logic sys_clk, rst_n, error_correction_enable, tx_in_valid, tx_in_ready, tx_in_last;
    logic tx_out_valid, tx_out_ready, tx_out_bit, tx_out_last, rx_start, rx_in_valid;
    logic rx_in_ready, rx_in_bit, rx_out_valid, rx_out_ready, rx_out_last, slow, go, done;
    logic [1:0] length_format;
    logic [7:0] tx_in_data, payload_len, rx_out_data, flip_at;
    logic [7:0] pay[4];
    logic exp_q[$];
    int err_count, num_checks;
    fci_codec u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .error_correction_enable(error_correction_enable), .length_format(length_format),
        .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data),
        .tx_in_last(tx_in_last), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
        .tx_out_bit(tx_out_bit), .tx_out_last(tx_out_last), .rx_start(rx_start),
        .payload_len(payload_len), .rx_in_valid(rx_in_valid), .rx_in_ready(rx_in_ready),
        .rx_in_bit(rx_in_bit), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
        .rx_out_data(rx_out_data), .rx_out_last(rx_out_last));
    fci_modem_model u_modem (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .go(go),
        .flip_at(flip_at), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
        .tx_out_bit(tx_out_bit), .tx_out_last(tx_out_last), .rx_in_valid(rx_in_valid),
        .rx_in_ready(rx_in_ready), .rx_in_bit(rx_in_bit), .done(done));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task print_verdict;
        if (err_count == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic give_up;
        err_count++;
        print_verdict();
    endtask : give_up
    // reference air stream: raw bytes msb first, or coded, padded and read by columns
    function automatic void build(input logic coded, input int n);
        logic [15:0] mat;
        logic [2:0] s;
        logic [7:0] b;
        int nb;
        exp_q.delete();
        s = 3'h0;
        nb = coded ? n + ((n % 2) ? 1 : 2) : n;
        for (int j = 0; j < nb; j++) begin
            b = (j < n) ? pay[j] : 8'h00;
            for (int i = 0; i < 8; i++) begin
                mat[2*i] = ^({b[7-i], s} & GEN_A);
                mat[2*i+1] = ^({b[7-i], s} & GEN_B);
                s = {b[7-i], s[2:1]};
                if (!coded) exp_q.push_back(b[7-i]);
            end
            for (int k = 0; coded && k < 16; k++) begin
                exp_q.push_back(mat[4*(k%4)+k/4]);
            end
        end
    endfunction : build
    task automatic do_pkt(input logic fec, input logic [1:0] fmt, input int n, input logic sl,
        input logic [7:0] fl, input int hold);
        int w;
        build(fec && fmt == LEN_FIXED, n);
        error_correction_enable = fec;
        length_format = fmt;
        slow = sl;
        flip_at = fl;
        for (int j = 0; j < n; j++) begin
            tx_in_data = pay[j];
            tx_in_last = (j == n - 1);
            tx_in_valid = 1'b1;
            // ready is judged one step after the edge, where it has settled
            for (w = 0; !tx_in_ready && w < 5000; w++) begin
                @(posedge sys_clk);
                #1;
            end
            if (w >= 5000) give_up();
            @(posedge sys_clk);
            #1;
        end
        tx_in_valid = 1'b0;
        tx_in_last = 1'b0;
        for (w = 0; !done && w < 5000; w++) @(posedge sys_clk);
        if (w >= 5000) give_up();
        chk(u_modem.cap_q.size(), exp_q.size());
        for (int i = 0; i < exp_q.size(); i++) chk(u_modem.cap_q[i], exp_q[i]);
        @(posedge sys_clk);
        #1;
        rx_start = 1'b1;
        payload_len = n[7:0];
        go = 1'b1;
        rx_out_ready = 1'b0;
        @(posedge sys_clk);
        #1;
        rx_start = 1'b0;
        go = 1'b0;
        repeat (hold) @(posedge sys_clk);
        #1;
        if (hold > 0) chk(rx_out_valid, 1'b1);
        rx_out_ready = 1'b1;
        for (int j = 0; j < n; j++) begin
            for (w = 0; !rx_out_valid && w < 5000; w++) begin
                @(posedge sys_clk);
                #1;
            end
            if (w >= 5000) give_up();
            chk(rx_out_data, pay[j]);
            chk(rx_out_last, j == n - 1);
            @(posedge sys_clk);
            #1;
        end
        repeat (60) @(posedge sys_clk);
        #1;
        chk(rx_out_valid, 1'b0);
    endtask : do_pkt
    task automatic t_raw;
        pay = '{8'ha5, 8'h3c, 8'h01, 8'h00};
        do_pkt(1'b0, LEN_FIXED, 3, 1'b0, 8'hff, 0);
    endtask : t_raw
    task automatic t_var_len;
        pay = '{8'h81, 8'h7e, 8'h00, 8'h00};
        // coding is requested outside fixed length, but fec_ok gates it off, so the block stays raw
        for (int f = 1; f < 4; f++) do_pkt(1'b1, f[1:0], 2, 1'b0, 8'hff, 0);
    endtask : t_var_len
    task automatic t_fec_even;
        pay = '{8'hc3, 8'h5a, 8'h00, 8'h00};
        do_pkt(1'b1, LEN_FIXED, 2, 1'b1, 8'hff, 0);
    endtask : t_fec_even
    task automatic t_fec_odd;
        pay = '{8'hff, 8'h00, 8'h96, 8'h00};
        // one corrupt symbol and a stalled reader: byte values must survive both
        do_pkt(1'b1, LEN_FIXED, 3, 1'b0, 8'd21, 300);
    endtask : t_fec_odd
    initial begin
        err_count = 0;
        num_checks = 0;
        rst_n = 1'b0;
        error_correction_enable = 1'b0;
        length_format = LEN_FIXED;
        tx_in_valid = 1'b0;
        tx_in_data = 8'h00;
        tx_in_last = 1'b0;
        rx_start = 1'b0;
        payload_len = 8'h00;
        rx_out_ready = 1'b0;
        slow = 1'b0;
        go = 1'b0;
        flip_at = 8'hff;
        repeat (4) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        t_raw();
        t_var_len();
        t_fec_even();
        t_fec_odd();
        print_verdict();
    end
endmodule : tb_fci_codec
`default_nettype wire
